/* src/eifm_event_irq_flag_mask.sv */
// module: event flag latching, enable masks, vectors and APB register slave
`timescale 1ns/1ns
module eifm_event_irq_flag_mask (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire eifm_pkg::eifm_apb_req_t apbReq,
  output eifm_pkg::eifm_apb_rsp_t apbRsp,
  input wire eifm_pkg::eifm_events_t events,
  output logic irqReqB,
  output logic irqReqC,
  output logic irq
);

  // ************************************************************
  // helpers
  // ************************************************************

  // byte address of a register index
  function automatic logic [31:0] byteAddr(input logic [15:0] idx);
    byteAddr = {14'h0000, idx, 2'b00};
  endfunction : byteAddr

  // lowest set bit wins; zero when nothing pending
  function automatic logic [eifm_pkg::VEC_W-1:0] vecOf(
    input logic [3:0] pend,
    input logic [eifm_pkg::VEC_W-1:0] base
  );
    vecOf = 6'h00;
    for (int i = 3; i >= 0; i--) begin
      if (pend[i]) begin
        vecOf = base + 6'(i);
      end
    end
  endfunction : vecOf

  eifm_pkg::eifm_state_t stateQ;
  eifm_pkg::eifm_state_t stateD;

  logic setupPhase;
  logic accessDone;
  logic wrDone;
  logic [3:0] pendB;
  logic [3:0] pendC;
  logic [eifm_pkg::VEC_W-1:0] vecB;
  logic [eifm_pkg::VEC_W-1:0] vecC;
  logic [eifm_pkg::FLGB_W-1:0] newB;
  logic [eifm_pkg::FLGC_W-1:0] newC;
  logic [31:0] readVal;
  logic addrHit;

  // ************************************************************
  // bus phases
  // ************************************************************

  // no wait state: read data is sampled in setup, so access ends in the first access cycle with ce high
  assign setupPhase = apbReq.psel && !apbReq.penable && ce;
  assign accessDone = apbReq.psel && apbReq.penable && ce;
  assign wrDone = accessDone && apbReq.pwrite;

  // pending sets and vectors
  assign pendB = {1'b0, stateQ.flagsB & stateQ.enableB[eifm_pkg::FLGB_W-1:0]};
  assign pendC = stateQ.flagsC & stateQ.enableC;
  assign vecB = vecOf(pendB, eifm_pkg::VEC_BASE_B);
  assign vecC = vecOf(pendC, eifm_pkg::VEC_BASE_C);
  assign newB = events.t2Event & stateQ.enableB[eifm_pkg::FLGB_W-1:0];
  assign newC = events.capEvent & stateQ.enableC;

  // ************************************************************
  // read decode
  // ************************************************************

  // unused and reserved bits are zero-extended, so they always read zero
  always_comb begin
    readVal = 32'h0000_0000;
    addrHit = 1'b1;
    case (apbReq.paddr)
      byteAddr(eifm_pkg::IDX_ENABLE_A): readVal = 32'(stateQ.enableA);
      byteAddr(eifm_pkg::IDX_ENABLE_B): readVal = 32'(stateQ.enableB);
      byteAddr(eifm_pkg::IDX_ENABLE_C): readVal = 32'(stateQ.enableC);
      byteAddr(eifm_pkg::IDX_FLAGS_B): readVal = 32'(stateQ.flagsB);
      byteAddr(eifm_pkg::IDX_CAP_FLAGS): readVal = 32'(stateQ.flagsC);
      byteAddr(eifm_pkg::IDX_VECTOR_B): readVal = 32'(vecB);
      byteAddr(eifm_pkg::IDX_VECTOR_C): readVal = 32'(vecC);
      byteAddr(eifm_pkg::IDX_IRQ_STATUS): readVal = 32'(stateQ.irqStatus);
      byteAddr(eifm_pkg::IDX_IRQ_MASK): readVal = 32'(stateQ.irqMask);
      default: addrHit = 1'b0;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************

  // clear first, then OR in the new events so a same-cycle event survives
  always_comb begin
    stateD = stateQ;
    if (setupPhase) begin
      stateD.rdata = readVal;
      stateD.errLatch = !addrHit;
    end
    if (wrDone && addrHit) begin
      case (apbReq.paddr)
        byteAddr(eifm_pkg::IDX_ENABLE_A): begin
          stateD.enableA = apbReq.pwdata[eifm_pkg::ENA_W-1:0];
        end
        byteAddr(eifm_pkg::IDX_ENABLE_B): begin
          stateD.enableB = apbReq.pwdata[eifm_pkg::ENB_W-1:0];
        end
        byteAddr(eifm_pkg::IDX_ENABLE_C): begin
          stateD.enableC = apbReq.pwdata[eifm_pkg::ENC_W-1:0];
        end
        byteAddr(eifm_pkg::IDX_FLAGS_B): begin
          stateD.flagsB = stateQ.flagsB & ~apbReq.pwdata[eifm_pkg::FLGB_W-1:0];
        end
        byteAddr(eifm_pkg::IDX_CAP_FLAGS): begin
          stateD.flagsC = stateQ.flagsC & ~apbReq.pwdata[eifm_pkg::FLGC_W-1:0];
        end
        byteAddr(eifm_pkg::IDX_IRQ_STATUS): begin
          stateD.irqStatus = stateQ.irqStatus & ~apbReq.pwdata[eifm_pkg::STS_W-1:0];
        end
        byteAddr(eifm_pkg::IDX_IRQ_MASK): begin
          stateD.irqMask = apbReq.pwdata[eifm_pkg::STS_W-1:0];
        end
        default: begin
          stateD.irqMask = stateD.irqMask;
        end
      endcase
    end
    // events latch whatever the enables say; the enables only gate requests
    stateD.flagsB = stateD.flagsB | events.t2Event;
    stateD.flagsC = stateD.flagsC | events.capEvent;
    stateD.irqStatus[eifm_pkg::STS_GRP_B] = stateD.irqStatus[eifm_pkg::STS_GRP_B] | (|newB);
    stateD.irqStatus[eifm_pkg::STS_GRP_C] = stateD.irqStatus[eifm_pkg::STS_GRP_C] | (|newC);
  end

  // ************************************************************
  // state register
  // ************************************************************

  // clock enable freezes everything, including the bus answer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stateQ.enableA <= eifm_pkg::ENA_RESET;
      stateQ.enableB <= eifm_pkg::ENB_RESET;
      stateQ.enableC <= eifm_pkg::ENC_RESET;
      stateQ.flagsB <= eifm_pkg::FLGB_RESET;
      stateQ.flagsC <= eifm_pkg::FLGC_RESET;
      stateQ.irqStatus <= eifm_pkg::STS_RESET;
      stateQ.irqMask <= eifm_pkg::STS_RESET;
      stateQ.rdata <= 32'h0000_0000;
      stateQ.errLatch <= 1'b0;
    end else if (ce) begin
      stateQ <= stateD;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign apbRsp.pready = accessDone;
  assign apbRsp.pslverr = accessDone && stateQ.errLatch;
  assign apbRsp.prdata = stateQ.rdata;
  assign irqReqB = |pendB;
  assign irqReqC = |pendC;
  assign irq = |(stateQ.irqStatus & stateQ.irqMask);

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  property p_cap_set;
    ce && events.capEvent[0] |=> stateQ.flagsC[0];
  endproperty
  a_cap_set: assert property (p_cap_set) else $error("capture event not latched");

  property p_event_wins;
    wrDone && apbReq.paddr == byteAddr(eifm_pkg::IDX_FLAGS_B) && apbReq.pwdata[2]
      && events.t2Event[2] |=> stateQ.flagsB[2];
  endproperty
  a_event_wins: assert property (p_event_wins) else $error("event lost to clear");

  property p_w1c;
    wrDone && apbReq.paddr == byteAddr(eifm_pkg::IDX_CAP_FLAGS) && apbReq.pwdata[1]
      && !events.capEvent[1] |=> !stateQ.flagsC[1];
  endproperty
  a_w1c: assert property (p_w1c) else $error("one write did not clear flag");

  property p_w0_keeps;
    wrDone && apbReq.paddr == byteAddr(eifm_pkg::IDX_FLAGS_B) && !apbReq.pwdata[0]
      && stateQ.flagsB[0] |=> stateQ.flagsB[0];
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) else $error("zero write changed flag");

  property p_cap_reserved;
    setupPhase && !apbReq.pwrite && apbReq.paddr == byteAddr(eifm_pkg::IDX_CAP_FLAGS)
      |=> apbRsp.prdata[31:4] == 28'h0;
  endproperty
  a_cap_reserved: assert property (p_cap_reserved) else $error("reserved bits not zero");

  property p_ena_write;
    wrDone && apbReq.paddr == byteAddr(eifm_pkg::IDX_ENABLE_A)
      |=> stateQ.enableA == $past(apbReq.pwdata[10:0]);
  endproperty
  a_ena_write: assert property (p_ena_write) else $error("first mask write lost");

  property p_req_b;
    ce && events.t2Event[1] && stateQ.enableB[1] |=> irqReqB && vecB != 6'h00;
  endproperty
  a_req_b: assert property (p_req_b) else $error("group request missing");

  property p_vec_zero;
    pendC == 4'h0 |-> vecC == 6'h00 && !irqReqC;
  endproperty
  a_vec_zero: assert property (p_vec_zero) else $error("vector not zero when idle");

  property p_vec_prio;
    pendC[0] |-> vecC == eifm_pkg::VEC_BASE_C;
  endproperty
  a_vec_prio: assert property (p_vec_prio) else $error("vector priority wrong");

  property p_unmapped;
    setupPhase && !addrHit ##1 accessDone |-> apbRsp.pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  // ************************************************************
  // per-bit flag and mask checks
  // ************************************************************

  // each timer two event lands at its own bit, whatever the enables hold
  property p_t2_under;
    ce && events.t2Event[2] |=> stateQ.flagsB[2];
  endproperty
  a_t2_under: assert property (p_t2_under) else $error("underflow flag not set");

  property p_t2_cmp;
    ce && events.t2Event[1] |=> stateQ.flagsB[1];
  endproperty
  a_t2_cmp: assert property (p_t2_cmp) else $error("compare flag not set");

  property p_t2_per;
    ce && events.t2Event[0] |=> stateQ.flagsB[0];
  endproperty
  a_t2_per: assert property (p_t2_per) else $error("period flag not set");

  // every capture line, not only the first, must reach its flag
  property p_cap_all;
    ce && (|events.capEvent)
      |=> (stateQ.flagsC & $past(events.capEvent)) == $past(events.capEvent);
  endproperty
  a_cap_all: assert property (p_cap_all) else $error("capture flag missing");

  // a flag with no event and no write keeps its value
  property p_cap_hold;
    ce && !(|events.capEvent) && !wrDone |=> stateQ.flagsC == $past(stateQ.flagsC);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture flag moved");

  property p_flagb_hold;
    ce && !(|events.t2Event) && !wrDone |=> stateQ.flagsB == $past(stateQ.flagsB);
  endproperty
  a_flagb_hold: assert property (p_flagb_hold) else $error("timer flag moved");

  // reads return the flags as they stood in the setup cycle
  property p_flagb_read;
    setupPhase && !apbReq.pwrite && apbReq.paddr == byteAddr(eifm_pkg::IDX_FLAGS_B)
      |=> apbRsp.prdata == 32'($past(stateQ.flagsB));
  endproperty
  a_flagb_read: assert property (p_flagb_read) else $error("timer flag read wrong");

  property p_cap_read;
    setupPhase && !apbReq.pwrite && apbReq.paddr == byteAddr(eifm_pkg::IDX_CAP_FLAGS)
      |=> apbRsp.prdata == 32'($past(stateQ.flagsC));
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("capture flag read wrong");

  // first mask: reserved bits read zero, implemented bits take the written value
  property p_ena_reserved;
    setupPhase && !apbReq.pwrite && apbReq.paddr == byteAddr(eifm_pkg::IDX_ENABLE_A)
      |=> apbRsp.prdata[31:11] == 21'h0;
  endproperty
  a_ena_reserved: assert property (p_ena_reserved) else $error("mask a reserved set");

  property p_ena_simple;
    wrDone && apbReq.paddr == byteAddr(eifm_pkg::IDX_ENABLE_A)
      |=> stateQ.enableA[6:4] == $past(apbReq.pwdata[6:4]);
  endproperty
  a_ena_simple: assert property (p_ena_simple) else $error("simple enables lost");

  property p_ena_full;
    wrDone && apbReq.paddr == byteAddr(eifm_pkg::IDX_ENABLE_A)
      |=> stateQ.enableA[3:0] == $past(apbReq.pwdata[3:0]);
  endproperty
  a_ena_full: assert property (p_ena_full) else $error("full enables lost");

  property p_enb_write;
    wrDone && apbReq.paddr == byteAddr(eifm_pkg::IDX_ENABLE_B)
      |=> stateQ.enableB == $past(apbReq.pwdata[7:0]);
  endproperty
  a_enb_write: assert property (p_enb_write) else $error("second mask write lost");

  property p_enc_write;
    wrDone && apbReq.paddr == byteAddr(eifm_pkg::IDX_ENABLE_C)
      |=> stateQ.enableC == $past(apbReq.pwdata[3:0]);
  endproperty
  a_enc_write: assert property (p_enc_write) else $error("capture mask write lost");

  // group requests and vectors follow the enabled flags
  property p_req_c;
    ce && events.capEvent[0] && stateQ.enableC[0] && !wrDone |=> irqReqC;
  endproperty
  a_req_c: assert property (p_req_c) else $error("capture request missing");

  property p_vec_b_zero;
    pendB == 4'h0 |-> vecB == 6'h00 && !irqReqB;
  endproperty
  a_vec_b_zero: assert property (p_vec_b_zero) else $error("vector b not zero");

  property p_vec_b_prio;
    pendB[0] |-> vecB == eifm_pkg::VEC_BASE_B;
  endproperty
  a_vec_b_prio: assert property (p_vec_b_prio) else $error("vector b priority wrong");

endmodule : eifm_event_irq_flag_mask

/* src/eifm_pkg.sv */
// package: register map, field layout, reset values and carriers of the event flag/mask block
package eifm_pkg;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [15:0] IDX_ENABLE_A = 16'h742c;
  localparam logic [15:0] IDX_ENABLE_B = 16'h742d;
  localparam logic [15:0] IDX_ENABLE_C = 16'h742e;
  localparam logic [15:0] IDX_FLAGS_B = 16'h7430;
  localparam logic [15:0] IDX_CAP_FLAGS = 16'h7431;
  localparam logic [15:0] IDX_VECTOR_B = 16'h7433;
  localparam logic [15:0] IDX_VECTOR_C = 16'h7434;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h7440;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h7441;

  // ************************************************************
  // field widths and positions
  // ************************************************************
  localparam int ENA_W = 11;
  localparam int ENB_W = 8;
  localparam int ENC_W = 4;
  localparam int FLGB_W = 3;
  localparam int FLGC_W = 4;
  localparam int VEC_W = 6;
  localparam int STS_W = 2;
  localparam int STS_GRP_B = 0;
  localparam int STS_GRP_C = 1;
  localparam int T2_UNDERFLOW_BIT = 2;
  localparam int T2_COMPARE_BIT = 1;
  localparam int T2_PERIOD_BIT = 0;

  // ************************************************************
  // reset values and vector bases
  // ************************************************************
  localparam logic [ENA_W-1:0] ENA_RESET = 11'h000;
  localparam logic [ENB_W-1:0] ENB_RESET = 8'h00;
  localparam logic [ENC_W-1:0] ENC_RESET = 4'h0;
  localparam logic [FLGB_W-1:0] FLGB_RESET = 3'h0;
  localparam logic [FLGC_W-1:0] FLGC_RESET = 4'h0;
  localparam logic [STS_W-1:0] STS_RESET = 2'h0;
  localparam logic [VEC_W-1:0] VEC_BASE_B = 6'h01;
  localparam logic [VEC_W-1:0] VEC_BASE_C = 6'h10;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } eifm_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } eifm_apb_rsp_t;

  typedef struct packed {
    logic [FLGC_W-1:0] capEvent;
    logic [FLGB_W-1:0] t2Event;
  } eifm_events_t;

  typedef struct packed {
    logic [ENA_W-1:0] enableA;
    logic [ENB_W-1:0] enableB;
    logic [ENC_W-1:0] enableC;
    logic [FLGB_W-1:0] flagsB;
    logic [FLGC_W-1:0] flagsC;
    logic [STS_W-1:0] irqStatus;
    logic [STS_W-1:0] irqMask;
    logic [31:0] rdata;
    logic errLatch;
  } eifm_state_t;

endpackage : eifm_pkg

/* test/eifm_event_irq_flag_mask_bench.sv */
// testbench: apb register traffic, event pulses and request checks for the flag/mask block
`timescale 1ns/1ns
module eifm_event_irq_flag_mask_bench;
  // ************************************************************
  // signals and instance
  // ************************************************************
  logic clk;
  logic arstN;
  logic ce;
  eifm_pkg::eifm_apb_req_t apbReq;
  eifm_pkg::eifm_apb_rsp_t apbRsp;
  eifm_pkg::eifm_events_t ev;
  logic irqReqB;
  logic irqReqC;
  logic irq;
  logic [32:0] expQ[$];
  int failures;
  int samplesChecked;
  int cycles;
  int i;
  logic [31:0] rnd;

  eifm_event_irq_flag_mask u_dut (
    .clk(clk),
    .arst_n(arstN),
    .ce(ce),
    .apbReq(apbReq),
    .apbRsp(apbRsp),
    .events(ev),
    .irqReqB(irqReqB),
    .irqReqC(irqReqC),
    .irq(irq)
  );

  // ************************************************************
  // compare, bus and event tasks
  // ************************************************************
  task automatic cmpRead(input logic [32:0] exp, input logic [32:0] got);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmpRead

  task automatic cmpLevel(input logic exp, input logic got);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmpLevel

  // one apb transfer; waits on pready, only the cycle ceiling ends a hang
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {14'h0, idx, 2'h0}, pwdata: d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (apbRsp.pready !== 1'b1);
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  // the note goes in before the bus moves, so the monitor always finds it
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic err);
    expQ.push_back({err, exp});
    xfer(1'b0, idx, 32'h0);
  endtask : rd

  task automatic pulse(input logic [3:0] cap, input logic [2:0] t2);
    @(posedge clk);
    ev <= '{capEvent: cap, t2Event: t2};
    @(posedge clk);
    ev <= '0;
  endtask : pulse

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // clock and hang guard; the ceiling is far above the few hundred cycles used
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  // read data is taken only at the edge that completes the access
  always @(posedge clk) begin
    if (apbReq.psel && apbReq.penable && apbRsp.pready === 1'b1 && !apbReq.pwrite) begin
      if (expQ.size() > 0) cmpRead(expQ.pop_front(), {apbRsp.pslverr, apbRsp.prdata});
      else failures++;
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    arstN = 1'b0;
    ce = 1'b1;
    apbReq = '0;
    ev = '0;
    void'($urandom(32'h74b0));
    repeat (10) @(posedge clk);
    arstN <= 1'b1;
    rd(eifm_pkg::IDX_ENABLE_A, 32'h0, 1'b0);
    rd(eifm_pkg::IDX_ENABLE_B, 32'h0, 1'b0);
    rd(eifm_pkg::IDX_CAP_FLAGS, 32'h0, 1'b0);
    rd(eifm_pkg::IDX_FLAGS_B, 32'h0, 1'b0);
    rd(eifm_pkg::IDX_VECTOR_C, 32'h0, 1'b0);
    done("reset");
    wr(eifm_pkg::IDX_ENABLE_A, 32'hffffffff);
    rd(eifm_pkg::IDX_ENABLE_A, 32'h7ff, 1'b0);
    for (i = 0; i < 11; i++) begin
      wr(eifm_pkg::IDX_ENABLE_A, 32'h1 << i);
      rd(eifm_pkg::IDX_ENABLE_A, 32'h1 << i, 1'b0);
    end
    rnd = $urandom;
    wr(eifm_pkg::IDX_ENABLE_B, rnd);
    rd(eifm_pkg::IDX_ENABLE_B, rnd & 32'hff, 1'b0);
    done("masks");
    for (i = 0; i < 4; i++) begin
      pulse(4'h1 << i, 3'h0);
      rd(eifm_pkg::IDX_CAP_FLAGS, 32'h1 << i, 1'b0);
      wr(eifm_pkg::IDX_CAP_FLAGS, 32'h1 << i);
    end
    for (i = 0; i < 3; i++) begin
      pulse(4'h0, 3'h1 << i);
      rd(eifm_pkg::IDX_FLAGS_B, 32'h1 << i, 1'b0);
      wr(eifm_pkg::IDX_FLAGS_B, 32'h1 << i);
    end
    rnd = $urandom & 32'hf;
    pulse(rnd[3:0], 3'h0);
    rd(eifm_pkg::IDX_CAP_FLAGS, rnd, 1'b0);
    pulse(4'hf, 3'h0);
    wr(eifm_pkg::IDX_CAP_FLAGS, 32'hfffffff0);
    rd(eifm_pkg::IDX_CAP_FLAGS, 32'hf, 1'b0);
    wr(eifm_pkg::IDX_CAP_FLAGS, 32'h5);
    rd(eifm_pkg::IDX_CAP_FLAGS, 32'ha, 1'b0);
    wr(eifm_pkg::IDX_CAP_FLAGS, 32'ha);
    rd(eifm_pkg::IDX_CAP_FLAGS, 32'h0, 1'b0);
    done("flags");
    wr(eifm_pkg::IDX_ENABLE_C, 32'hc);
    wr(eifm_pkg::IDX_ENABLE_B, 32'h6);
    pulse(4'ha, 3'h7);
    @(negedge clk);
    cmpLevel(1'b1, irqReqC);
    cmpLevel(1'b1, irqReqB);
    cmpLevel(1'b0, irq);
    rd(eifm_pkg::IDX_VECTOR_C, {26'h0, eifm_pkg::VEC_BASE_C + 6'h3}, 1'b0);
    rd(eifm_pkg::IDX_VECTOR_B, {26'h0, eifm_pkg::VEC_BASE_B + 6'h1}, 1'b0);
    wr(eifm_pkg::IDX_IRQ_MASK, 32'h2);
    @(negedge clk);
    cmpLevel(1'b1, irq);
    wr(eifm_pkg::IDX_IRQ_STATUS, 32'h2);
    @(negedge clk);
    cmpLevel(1'b0, irq);
    rd(eifm_pkg::IDX_IRQ_STATUS, 32'h1, 1'b0);
    done("requests");
    // the clearing write and a fresh event meet at the same edge
    fork
      wr(eifm_pkg::IDX_CAP_FLAGS, 32'h2);
      begin
        repeat (2) @(posedge clk);
        ev.capEvent <= 4'h2;
        @(posedge clk);
        ev <= '0;
      end
    join
    rd(eifm_pkg::IDX_CAP_FLAGS, 32'ha, 1'b0);
    wr(16'h7450, 32'hffffffff);
    rd(16'h7450, 32'h0, 1'b1);
    // clock enable dropped in the access phase must stretch the transfer
    fork
      rd(eifm_pkg::IDX_ENABLE_B, 32'h6, 1'b0);
      begin
        repeat (2) @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
      end
    join
    done("corners");
    repeat (2) @(posedge clk);
    final_report();
  end
endmodule : eifm_event_irq_flag_mask_bench
